/* hdl/pmt_pkg.sv */
// Constants and types shared by the program memory and table read block
package pmt_pkg;
  localparam int          ADDR_W        = 13;
  localparam int          WORD_W        = 16;
  localparam int          BYTE_W        = 8;
  localparam int          DEPTH         = 8192;
  localparam int          PTR_HI_W      = 5;
  localparam int          DEST_W        = 16;
  localparam int          SECTOR_LSB    = 8;
  localparam int          HIGH_LSB      = 8;
  localparam int          CNT_W         = 5;
  localparam logic [ADDR_W-1:0]   RESET_VECTOR  = 13'h0000;
  localparam logic [PTR_HI_W-1:0] LAST_PAGE_HI  = 5'h1F;
  localparam logic [7:0]          SECTOR_ZERO   = 8'h00;
  localparam logic                ICP_CMD_WRITE = 1'b1;
  localparam logic [CNT_W-1:0]    ICP_ADDR_LAST = 5'h0C;
  localparam logic [CNT_W-1:0]    ICP_DATA_LAST = 5'h0F;

  typedef struct packed {
    logic              extended;
    logic              last_page;
    logic [DEST_W-1:0] dest;
  } pmt_req_type;

  typedef struct packed {
    logic [DEST_W-1:0] dest;
    logic [BYTE_W-1:0] low_byte;
  } pmt_res_type;

  typedef enum logic [1:0] {
    TBL_IDLE = 2'b00,
    TBL_ADDR = 2'b01,
    TBL_DATA = 2'b11
  } pmt_tbl_state_type;

  typedef enum logic [1:0] {
    ICP_CMD   = 2'b00,
    ICP_ADDR  = 2'b01,
    ICP_WDATA = 2'b11,
    ICP_RDATA = 2'b10
  } pmt_icp_state_type;
endpackage

/* hdl/pmt_program_memory.sv */
// Program store with fetch, table read and serial in-circuit programming
// Operation
// RULE1 - Store of 8K sixteen-bit words
// RULE2 - Fetch by counter, tables by separate pointer
// RULE3 - Counter starts at word zero after reset
// RULE4 - Table address joins low and high pointers
// RULE5 - Low byte goes to named destination
// RULE6 - High byte loads holding latch, extra bits zero
// RULE7 - Holding latch software readable and writable
// RULE8 - Table reads complete in two cycles
// RULE9 - Last-page forms force upper address to last page
// RULE10 - Basic forms reach sector zero only
// RULE11 - Serial programming: one data line, clock
// RULE12 - Nothing else drives programming lines meanwhile
// RULE13 - Data on port bit zero, clock bit two
// RULE14 - Thirteen-bit address: eight low, five high
module pmt_program_memory (
  input  wire logic                         i_clk,                  // System clock
  input  wire logic                         i_reset_n,              // Async reset, low
  input  wire logic                         i_pc_load,              // Load counter
  input  wire logic [pmt_pkg::ADDR_W-1:0]   i_pc_target,            // Jump target
  input  wire logic                         i_pc_inc,               // Advance counter
  output logic      [pmt_pkg::ADDR_W-1:0]   o_pc,                   // Program counter
  output logic      [pmt_pkg::WORD_W-1:0]   o_instr,                // Fetched word
  input  wire logic                         i_ptr_lo_we,            // Low pointer write
  input  wire logic                         i_ptr_hi_we,            // High pointer write
  input  wire logic                         i_table_high_latch_we,              // Holding latch write
  input  wire logic [pmt_pkg::BYTE_W-1:0]   i_wdata,                // Write data
  output logic      [pmt_pkg::BYTE_W-1:0]   o_ptr_lo,               // Low pointer
  output logic      [pmt_pkg::BYTE_W-1:0]   o_ptr_hi,               // High pointer
  output logic      [pmt_pkg::BYTE_W-1:0]   o_table_high_latch,     // Holding latch
  input  wire logic                         i_tbl_req,              // Table read request
  input  wire pmt_pkg::pmt_req_type         i_tbl_cmd,              // Form and destination
  output logic                              o_tbl_ready,            // Idle, a request can be taken
  output logic                              o_tbl_done,             // Result valid
  output pmt_pkg::pmt_res_type              o_tbl_res,              // Destination and byte
  output logic                              o_sector_fault,         // Refused request
  input  wire logic                         i_prog_enable,          // Programming mode
  input  wire logic                         i_port_a_bit_zero,      // Pin level, bit 0
  output logic                              o_port_a_bit_zero,      // Pin drive, bit 0
  output logic                              o_port_a_bit_zero_oe_n, // Enable, bit 0, low
  input  wire logic                         i_port_a_bit_two,       // Pin level, bit 2
  output logic                              o_port_a_bit_two,       // Pin drive, bit 2
  output logic                              o_port_a_bit_two_oe_n,  // Enable, bit 2, low
  input  wire logic [1:0]                   i_gpio_out,             // Port drive {b2,b0}
  input  wire logic [1:0]                   i_gpio_oe_n,            // Port enable {b2,b0}
  output logic      [1:0]                   o_gpio_in               // Port level {b2,b0}
);
  logic [pmt_pkg::WORD_W-1:0]   mem [pmt_pkg::DEPTH];
  logic [pmt_pkg::ADDR_W-1:0]   pc_q;
  logic [pmt_pkg::WORD_W-1:0]   instr_q;
  logic [pmt_pkg::BYTE_W-1:0]   ptr_lo_q;
  logic [pmt_pkg::BYTE_W-1:0]   ptr_hi_q;
  logic [pmt_pkg::BYTE_W-1:0]   table_high_latch_q;
  pmt_pkg::pmt_tbl_state_type   tbl_state_q;
  logic [pmt_pkg::ADDR_W-1:0]   tbl_addr_q;
  logic [pmt_pkg::ADDR_W-1:0]   tbl_addr_d;
  logic [pmt_pkg::DEST_W-1:0]   tbl_dest_q;
  logic [pmt_pkg::BYTE_W-1:0]   tbl_low_q;
  logic [pmt_pkg::WORD_W-1:0]   tbl_word;
  logic                         tbl_take;
  logic                         tbl_bad_sector;
  logic                         fault_q;
  logic                         table_high_latch_load;
  pmt_pkg::pmt_icp_state_type   icp_state_q;
  logic [pmt_pkg::CNT_W-1:0]    icp_cnt_q;
  logic                         icp_write_q;
  logic [pmt_pkg::ADDR_W-1:0]   icp_addr_q;
  logic [pmt_pkg::ADDR_W-1:0]   icp_addr_d;
  logic [pmt_pkg::WORD_W-1:0]   icp_sr_q;
  logic                         icp_clk_prev_q;
  logic                         icp_rise;
  logic                         icp_bit;
  logic                         icp_wr_en;
  logic [pmt_pkg::WORD_W-1:0]   icp_wr_word;
  logic                         rst_seen_q;

  // Program counter; reset entry is word zero
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pc_q <= pmt_pkg::RESET_VECTOR;                                 // [RULE3]
    end else if (i_pc_load) begin
      pc_q <= i_pc_target;
    end else if (i_pc_inc) begin
      pc_q <= pmt_pkg::ADDR_W'(pc_q + 1'b1);
    end
  end

  // Fetch path reads at the counter, independent of the table pointer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      instr_q <= '0;
    end else begin
      instr_q <= mem[pc_q];                                          // [RULE1] [RULE2]
    end
  end

  // Pointer registers written by the core
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ptr_lo_q <= '0;
      ptr_hi_q <= '0;
    end else begin
      if (i_ptr_lo_we) begin
        ptr_lo_q <= i_wdata;
      end
      if (i_ptr_hi_we) begin
        ptr_hi_q <= i_wdata;
      end
    end
  end

  assign o_tbl_ready    = (tbl_state_q == pmt_pkg::TBL_IDLE);
  assign tbl_take       = i_tbl_req && o_tbl_ready;
  assign tbl_bad_sector = !i_tbl_cmd.extended &&
                          (i_tbl_cmd.dest[pmt_pkg::DEST_W-1:pmt_pkg::SECTOR_LSB]
                           != pmt_pkg::SECTOR_ZERO);                 // [RULE10]

  // Upper pointer bits above the store width are ignored
  always_comb begin
    if (i_tbl_cmd.last_page) begin
      tbl_addr_d = {pmt_pkg::LAST_PAGE_HI, ptr_lo_q};                // [RULE9]
    end else begin
      tbl_addr_d = {ptr_hi_q[pmt_pkg::PTR_HI_W-1:0], ptr_lo_q};     // [RULE4] [RULE14]
    end
  end

  assign tbl_word  = mem[tbl_addr_q];
  assign table_high_latch_load = (tbl_state_q == pmt_pkg::TBL_ADDR);

  // Two-step sequencer: address capture, then word read
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tbl_state_q <= pmt_pkg::TBL_IDLE;
      tbl_addr_q  <= '0;
      tbl_dest_q  <= '0;
      tbl_low_q   <= '0;
    end else begin
      case (tbl_state_q)
        pmt_pkg::TBL_IDLE: begin
          if (tbl_take && !tbl_bad_sector) begin
            tbl_addr_q  <= tbl_addr_d;
            tbl_dest_q  <= i_tbl_cmd.dest;
            tbl_state_q <= pmt_pkg::TBL_ADDR;
          end
        end
        pmt_pkg::TBL_ADDR: begin
          tbl_low_q   <= tbl_word[pmt_pkg::BYTE_W-1:0];               // [RULE5]
          tbl_state_q <= pmt_pkg::TBL_DATA;                          // [RULE8]
        end
        pmt_pkg::TBL_DATA: begin
          tbl_state_q <= pmt_pkg::TBL_IDLE;
        end
        default: begin
          tbl_state_q <= pmt_pkg::TBL_IDLE;
        end
      endcase
    end
  end

  // Refusal shows as a pulse; no destination write follows it
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= tbl_take && tbl_bad_sector;                         // [RULE10]
    end
  end

  // Hardware load wins over a software write in the same cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      table_high_latch_q <= '0;
    end else if (table_high_latch_load) begin
      table_high_latch_q <= tbl_word[pmt_pkg::WORD_W-1:pmt_pkg::HIGH_LSB];       // [RULE6]
    end else if (i_table_high_latch_we) begin
      table_high_latch_q <= i_wdata;                                             // [RULE7]
    end
  end

  // Programming link; pins are sampled synchronously
  assign icp_bit    = i_port_a_bit_zero;                             // [RULE13]
  assign icp_rise   = i_prog_enable && i_port_a_bit_two && !icp_clk_prev_q; // [RULE13]
  assign icp_addr_d = {icp_addr_q[pmt_pkg::ADDR_W-2:0], icp_bit};
  assign icp_wr_en  = icp_rise && (icp_state_q == pmt_pkg::ICP_WDATA) &&
                      (icp_cnt_q == pmt_pkg::ICP_DATA_LAST);
  assign icp_wr_word = {icp_sr_q[pmt_pkg::WORD_W-2:0], icp_bit};

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      icp_clk_prev_q <= 1'b0;
    end else begin
      icp_clk_prev_q <= i_port_a_bit_two;
    end
  end

  // Frame: command bit, 13 address bits MSB first, 16 data bits in or out
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      icp_state_q <= pmt_pkg::ICP_CMD;
      icp_cnt_q   <= '0;
      icp_write_q <= 1'b0;
      icp_addr_q  <= '0;
      icp_sr_q    <= '0;
    end else if (!i_prog_enable) begin
      icp_state_q <= pmt_pkg::ICP_CMD;
      icp_cnt_q   <= '0;
    end else if (icp_rise) begin
      case (icp_state_q)
        pmt_pkg::ICP_CMD: begin
          icp_write_q <= (icp_bit == pmt_pkg::ICP_CMD_WRITE);        // [RULE11]
          icp_cnt_q   <= '0;
          icp_state_q <= pmt_pkg::ICP_ADDR;
        end
        pmt_pkg::ICP_ADDR: begin
          icp_addr_q <= icp_addr_d;
          if (icp_cnt_q == pmt_pkg::ICP_ADDR_LAST) begin
            icp_cnt_q <= '0;
            if (icp_write_q) begin
              icp_state_q <= pmt_pkg::ICP_WDATA;
            end else begin
              icp_sr_q    <= mem[icp_addr_d];                        // [RULE11]
              icp_state_q <= pmt_pkg::ICP_RDATA;
            end
          end else begin
            icp_cnt_q <= pmt_pkg::CNT_W'(icp_cnt_q + 1'b1);
          end
        end
        pmt_pkg::ICP_WDATA, pmt_pkg::ICP_RDATA: begin
          icp_sr_q <= icp_wr_word;
          if (icp_cnt_q == pmt_pkg::ICP_DATA_LAST) begin
            icp_cnt_q   <= '0;
            icp_state_q <= pmt_pkg::ICP_CMD;
          end else begin
            icp_cnt_q <= pmt_pkg::CNT_W'(icp_cnt_q + 1'b1);
          end
        end
        default: begin
          icp_state_q <= pmt_pkg::ICP_CMD;
        end
      endcase
    end
  end

  // Memory array has no reset; contents survive device reset
  always_ff @(posedge i_clk) begin
    if (icp_wr_en) begin
      mem[icp_addr_q] <= icp_wr_word;                                // [RULE11]
    end
  end

  // Pin sharing; in programming mode the clock pin is input only.
  // The line must have no other driver then; nothing here can detect a clash.
  always_comb begin
    if (i_prog_enable) begin
      o_port_a_bit_zero      = icp_sr_q[pmt_pkg::WORD_W-1];          // [RULE13]
      o_port_a_bit_zero_oe_n = (icp_state_q != pmt_pkg::ICP_RDATA);  // [RULE12]
      o_port_a_bit_two       = 1'b0;
      o_port_a_bit_two_oe_n  = 1'b1;
    end else begin
      o_port_a_bit_zero      = i_gpio_out[0];
      o_port_a_bit_zero_oe_n = i_gpio_oe_n[0];
      o_port_a_bit_two       = i_gpio_out[1];
      o_port_a_bit_two_oe_n  = i_gpio_oe_n[1];
    end
  end

  assign o_gpio_in          = {i_port_a_bit_two, i_port_a_bit_zero};
  assign o_pc               = pc_q;
  assign o_instr            = instr_q;
  assign o_ptr_lo           = ptr_lo_q;
  assign o_ptr_hi           = ptr_hi_q;
  assign o_table_high_latch = table_high_latch_q;
  assign o_tbl_done         = (tbl_state_q == pmt_pkg::TBL_DATA);
  assign o_tbl_res          = '{dest: tbl_dest_q, low_byte: tbl_low_q};
  assign o_sector_fault     = fault_q;

  // Helper: low during reset and in the first cycle after reset release
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_seen_q <= 1'b0;
    end else begin
      rst_seen_q <= 1'b1;
    end
  end

  sequence s_good_take;
    tbl_take && !tbl_bad_sector;
  endsequence

  sequence s_two_step;
    !o_tbl_done ##1 o_tbl_done;
  endsequence

  a_reset_entry: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE3]
    !rst_seen_q |-> (o_pc == pmt_pkg::RESET_VECTOR)) else $error("pc not at reset entry");
  a_fetch_advance: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE2]
    (i_pc_inc && !i_pc_load) |=> (o_pc == pmt_pkg::ADDR_W'($past(o_pc) + 1'b1)))
    else $error("pc did not advance");
  a_table_timing: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE8]
    s_good_take |=> s_two_step ##1 o_tbl_ready) else $error("table read not two cycles");
  a_pointer_join: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE4]
    (s_good_take and !i_tbl_cmd.last_page) |=>
    (tbl_addr_q == {$past(ptr_hi_q[pmt_pkg::PTR_HI_W-1:0]), $past(ptr_lo_q)}))
    else $error("table address not from pointers");
  a_last_page: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE9]
    (s_good_take and i_tbl_cmd.last_page) |=>
    (tbl_addr_q == {pmt_pkg::LAST_PAGE_HI, $past(ptr_lo_q)})) else $error("last page wrong");
  a_low_byte: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE5]
    table_high_latch_load |=> o_tbl_done &&
    (o_tbl_res.low_byte == $past(tbl_word[pmt_pkg::BYTE_W-1:0])))
    else $error("low byte wrong");
  a_high_latch: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE6]
    table_high_latch_load |=>
    (o_table_high_latch == $past(tbl_word[pmt_pkg::WORD_W-1:pmt_pkg::HIGH_LSB])))
    else $error("latch wrong");
  a_latch_write: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE7]
    (i_table_high_latch_we && !table_high_latch_load) |=> (o_table_high_latch == $past(i_wdata)))
    else $error("latch write lost");
  a_sector_refuse: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE10]
    (tbl_take && tbl_bad_sector) |=> (o_sector_fault && o_tbl_ready) ##1 !o_tbl_done)
    else $error("bad sector not refused");
  a_icp_store: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE11]
    icp_wr_en |=> (mem[$past(icp_addr_q)] == $past(icp_wr_word))) else $error("icp write lost");
  a_pin_share: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE13]
    (i_prog_enable && icp_state_q == pmt_pkg::ICP_RDATA) |->
    (!o_port_a_bit_zero_oe_n && o_port_a_bit_two_oe_n)) else $error("pin share wrong");
endmodule

/* tb/pmt_programmer_model.sv */
// Serial programmer model that drives the in-circuit programming pins
module pmt_programmer_model (
  input  wire logic i_clk,    // System clock
  input  wire logic i_sda,    // Resolved data line
  output logic      o_sda,    // Data drive
  output logic      o_sda_en, // Data drive enable, high
  output logic      o_sck     // Programming clock
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_sda    = 1'b0;
    o_sda_en = 1'b0;
    o_sck    = 1'b0;
  end

  // Data moves only while the clock is low; sampled just before each rise
  task automatic put_bit(input logic b, input logic en, input logic keep, output logic s);
    @(posedge i_clk);
    o_sck    <= 1'b0;
    o_sda    <= b;
    o_sda_en <= en;
    repeat (2) @(posedge i_clk);
    s = i_sda;
    o_sck <= 1'b1;
    @(posedge i_clk);
    // Let go on the edge where the device sees the rise, the same edge on which it turns the line round
    if (!keep) o_sda_en <= 1'b0;
    @(posedge i_clk);
  endtask

  // Command bit, 13 address bits and 16 data bits, most significant first
  task automatic frame(input logic wr, input logic [12:0] a, input logic [15:0] d,
                       output logic [15:0] q);
    logic s;
    put_bit(wr, 1'b1, 1'b1, s);
    for (int i = 12; i >= 0; i--) put_bit(a[i], 1'b1, wr || (i > 0), s);
    for (int i = 15; i >= 0; i--) begin
      put_bit(d[i], wr, wr, s);
      q[i] = s;
    end
    @(posedge i_clk);
    o_sck    <= 1'b0;
    o_sda_en <= 1'b0;
  endtask
endmodule

/* tb/program_memory_table_read_tb_top.sv */
// Self-checking bench for the program memory and table read block
module program_memory_table_read_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 i_clk, i_reset_n, pc_load, pc_inc, lo_we, hi_we, table_high_latch_we;
  logic                 req, ready, done, fault, prog_en, float_q;
  logic                 pin0, pin2, d0, oe0_n, d2, oe2_n, p_sda, p_en, p_sck;
  logic [12:0]          pc_target, pc;
  logic [15:0]          instr, q;
  logic [7:0]           wdata, ptr_lo, ptr_hi, latch;
  logic [1:0]           gpio_out, gpio_oe_n, gpio_in;
  pmt_pkg::pmt_req_type cmd;
  pmt_pkg::pmt_res_type res;
  int                   bad_count;
  int                   n_checks;

  pmt_program_memory dut_u (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_pc_load(pc_load), .i_pc_target(pc_target),
    .i_pc_inc(pc_inc), .o_pc(pc), .o_instr(instr), .i_ptr_lo_we(lo_we),
    .i_ptr_hi_we(hi_we), .i_table_high_latch_we(table_high_latch_we), .i_wdata(wdata), .o_ptr_lo(ptr_lo),
    .o_ptr_hi(ptr_hi), .o_table_high_latch(latch), .i_tbl_req(req), .i_tbl_cmd(cmd),
    .o_tbl_ready(ready), .o_tbl_done(done), .o_tbl_res(res), .o_sector_fault(fault),
    .i_prog_enable(prog_en), .i_port_a_bit_zero(pin0), .o_port_a_bit_zero(d0),
    .o_port_a_bit_zero_oe_n(oe0_n), .i_port_a_bit_two(pin2), .o_port_a_bit_two(d2),
    .o_port_a_bit_two_oe_n(oe2_n), .i_gpio_out(gpio_out), .i_gpio_oe_n(gpio_oe_n),
    .o_gpio_in(gpio_in));

  pmt_programmer_model prog_u (
    .i_clk(i_clk), .i_sda(pin0), .o_sda(p_sda), .o_sda_en(p_en), .o_sck(p_sck));

  // Undriven lines toggle so a stale level never passes for data
  assign pin0 = !oe0_n ? d0 : (p_en ? p_sda : float_q);
  assign pin2 = !oe2_n ? d2 : (prog_en ? p_sck : float_q);

  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) float_q <= ~float_q;
  always @(posedge i_clk) if (prog_en && p_en && !oe0_n) chk1(1'b1, 1'b0);

  task automatic wrap_up;
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic wr_reg(input logic [2:0] sel, input logic [7:0] v);
    @(posedge i_clk);
    {table_high_latch_we, hi_we, lo_we} <= sel;
    wdata <= v;
    @(posedge i_clk);
    {table_high_latch_we, hi_we, lo_we} <= 3'b000;
  endtask

  task automatic do_reset;
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    #1;
    chk16({3'h0, pc}, 16'h0000);
    chk16(instr, 16'h0000);
    chk16({8'h00, latch}, 16'h0000);
    chk1(ready, 1'b1);
    @(posedge i_clk);
    i_reset_n <= 1'b1;
  endtask

  task automatic t_pins;
    @(posedge i_clk);
    gpio_oe_n <= 2'b00;
    gpio_out  <= 2'b10;
    @(posedge i_clk);
    #1;
    chk16({14'h0000, gpio_in}, 16'h0002);
    @(posedge i_clk);
    prog_en <= 1'b1;
    @(posedge i_clk);
    #1;
    chk1(oe2_n, 1'b1);
    chk1(oe0_n, 1'b1);
  endtask

  task automatic t_program;
    prog_u.frame(1'b1, 13'h0000, 16'hA55A, q);
    prog_u.frame(1'b1, 13'h0001, 16'h1234, q);
    prog_u.frame(1'b1, 13'h1F06, 16'h001A, q);
    prog_u.frame(1'b1, 13'h1F05, 16'h000F, q);
    prog_u.frame(1'b1, 13'h0345, 16'hBEEF, q);
    prog_u.frame(1'b0, 13'h0345, 16'h0000, q);
    chk16(q, 16'hBEEF);
    prog_u.frame(1'b0, 13'h1F06, 16'h0000, q);
    chk16(q, 16'h001A);
    @(posedge i_clk);
    prog_en   <= 1'b0;
    gpio_oe_n <= 2'b11;
  endtask

  task automatic t_fetch;
    do_reset();
    @(posedge i_clk);
    pc_inc <= 1'b1;
    #1;
    chk16(instr, 16'hA55A);
    @(posedge i_clk);
    pc_inc <= 1'b0;
    #1;
    chk16({3'h0, pc}, 16'h0001);
    @(posedge i_clk);
    pc_load   <= 1'b1;
    pc_target <= 13'h0345;
    #1;
    chk16(instr, 16'h1234);
    @(posedge i_clk);
    pc_load <= 1'b0;
    @(posedge i_clk);
    #1;
    chk16(instr, 16'hBEEF);
  endtask

  task automatic tbl_read(input logic ext, input logic lp, input logic [15:0] dest,
                          input logic [7:0] lo, input logic [7:0] hi);
    @(posedge i_clk);
    req <= 1'b1;
    cmd <= {ext, lp, dest};
    @(posedge i_clk);
    req <= 1'b0;
    #1;
    chk1(ready, 1'b0);
    chk1(done, 1'b0);
    @(posedge i_clk);
    #1;
    chk1(done, 1'b1);
    chk16(res.dest, dest);
    chk16({8'h00, res.low_byte}, {8'h00, lo});
    chk16({8'h00, latch}, {8'h00, hi});
    @(posedge i_clk);
    #1;
    chk1(done, 1'b0);
    chk1(ready, 1'b1);
  endtask

  task automatic t_table;
    wr_reg(3'b100, 8'h5C);
    #1;
    chk16({8'h00, latch}, 16'h005C);
    wr_reg(3'b001, 8'h06);
    wr_reg(3'b010, 8'h1F);
    tbl_read(1'b0, 1'b0, 16'h0010, 8'h1A, 8'h00);
    wr_reg(3'b001, 8'h05);
    wr_reg(3'b010, 8'h03);
    tbl_read(1'b0, 1'b1, 16'h0011, 8'h0F, 8'h00);
    tbl_read(1'b1, 1'b1, 16'h0411, 8'h0F, 8'h00);
    wr_reg(3'b001, 8'h45);
    wr_reg(3'b010, 8'hE3);
    #1;
    chk16({ptr_hi, ptr_lo}, 16'hE345);
    tbl_read(1'b0, 1'b0, 16'h00FF, 8'hEF, 8'hBE);
    tbl_read(1'b1, 1'b0, 16'h0310, 8'hEF, 8'hBE);
  endtask

  task automatic t_fault;
    @(posedge i_clk);
    req <= 1'b1;
    cmd <= {1'b0, 1'b0, 16'h0210};
    @(posedge i_clk);
    req <= 1'b0;
    #1;
    chk1(fault, 1'b1);
    chk1(ready, 1'b1);
    @(posedge i_clk);
    #1;
    chk1(fault, 1'b0);
    chk1(done, 1'b0);
    chk16(res.dest, 16'h0310);
  endtask

  // Programming frames dominate the run; a few thousand cycles covers all of it
  initial begin
    repeat (6000) @(posedge i_clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    i_clk = 1'b0;
    i_reset_n = 1'b0;
    {pc_load, pc_inc, lo_we, hi_we, table_high_latch_we, req, prog_en, float_q} = 8'h00;
    pc_target = 13'h0000;
    wdata = 8'h00;
    cmd = '0;
    gpio_out = 2'b00;
    gpio_oe_n = 2'b11;
    bad_count = 0;
    n_checks = 0;
    do_reset();
    t_pins();
    t_program();
    t_fetch();
    t_table();
    t_fault();
    wrap_up();
  end
endmodule
